// file: rtl/cprc_dev.sv
// Clock, power-mode and reset controller, device end.
// Registers are an APB slave on the link; core sits on the far side.
//
// Implementation choices: the register addresses and the APB slave port.
`include "cprc_cfg.svh"
`default_nettype none
// Functional notes
// - Main clock is internal RC after any reset
// - Two identical PLLs: system and USB
// - Software keeps PLL reference within input range
// - Multiplier accepts every integer 1 through 32
// - Software keeps oscillator inside its frequency window
// - Post divider only 2, 4, 8, 16
// - Software keeps PLL output below ceiling
// - PLLs off and bypassed after reset
// - Software switches to PLL only after lock
// - Clock out pin picks one of four
// - Cleared gate bit stops peripheral clock
// - Light sleep stops core until interrupt
// - Peripherals run and interrupt in light sleep
// - Deep sleep keeps RC and optional low-rate; RC output gated unless pmode bit 4
// - Deep sleep wakes on reset, GPIO, watchdog, USB
// - Power-down stops all but optional low-rate
// - Deepest mode: only wake pin or a chip reset (ext, watchdog, brownout) revives chip
// - Lock bit refuses deepest power-down entry
// - Four reset sources restart RC and flash
// - External low pulse of 50 ns resets
// - Registers reset, core fetches from zero
// - Brownout raises interrupt, status, optional reset
module cprc_dev
	import cprc_pkg::*;
#(
	parameter int NPER = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	cprc_link_if.dev link,
	input wire logic ext_resetn,
	input wire logic wdt_reset,
	input wire logic bod_low,
	input wire logic bod_trip,
	input wire logic wake_pin_n,
	input wire logic gpio_wake,
	input wire logic wdt_irq,
	input wire logic usb_irq,
	output logic [1:0] main_sel,
	output logic [1:0] clock_out_pin_sel,
	output logic irc_en,
	output logic irc_out_en,
	output logic sysosc_en,
	output logic lowrate_en,
	output logic [4:0] sys_pll_msel,
	output logic [1:0] sys_pll_psel,
	output logic sys_pll_on,
	output logic [4:0] usb_pll_msel,
	output logic [1:0] usb_pll_psel,
	output logic usb_pll_on,
	output logic [NPER-1:0] per_clk_en,
	output logic flash_init,
	output logic bod_irq
);
	if (NPER < 1 || NPER > 32) begin : g_chk
		$error("NPER must lie in 1..32");
	end

	localparam int LOCK_W = $clog2(`CPRC_PLL_LOCK_CYC + 1);
	localparam int HOLD_W = $clog2(`CPRC_CORE_HOLD_CYC + 1);
	localparam int RMIN_W = $clog2(`CPRC_RST_MIN_CYC + 1);
	localparam logic [LOCK_W-1:0] LOCK_CYC = LOCK_W'(`CPRC_PLL_LOCK_CYC);
	localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(`CPRC_CORE_HOLD_CYC);
	localparam logic [RMIN_W-1:0] RMIN_CYC = RMIN_W'(`CPRC_RST_MIN_CYC);

	typedef struct packed {
		logic [1:0] main_sel;
		logic [7:0] sys_pll;
		logic [7:0] usb_pll;
		logic [1:0] clock_out_pin_sel;
		logic [NPER-1:0] gate;
		logic [4:0] pmode;
		logic bod_rst_en;
	} cprc_cfg_t;

	// Flags: refused, ext, wdt, por, brownout reset, deepest wake
	typedef struct packed {
		cprc_cfg_t cfg;
		logic [5:0] flags;
		cprc_pwr_t pwr;
		logic [LOCK_W-1:0] sys_cnt;
		logic [LOCK_W-1:0] usb_cnt;
		logic [HOLD_W-1:0] hold;
		logic [RMIN_W-1:0] ext_low;
		logic [1:0] ext_sync;
		logic [1:0] wake_sync;
		logic [1:0] bodl_sync;
		logic [1:0] bodt_sync;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic core_rst_n;
		logic core_clk_en;
		logic [1:0] pll_lock;
		logic [31:0] fetch_addr;
		logic irc_en;
		logic irc_out_en;
		logic sysosc_en;
		logic lowrate_en;
		logic [NPER-1:0] per_en;
		logic flash_init;
		logic bod_irq;
		logic sys_on;
		logic usb_on;
	} cprc_dev_st_t;

	localparam cprc_cfg_t CFG_RST = '{
		main_sel: `CPRC_MAINSEL_RST,
		sys_pll: `CPRC_PLL_RST,
		usb_pll: `CPRC_PLL_RST,
		clock_out_pin_sel: `CPRC_CLOCK_OUT_PIN_RST,
		gate: '1,
		pmode: `CPRC_PMODE_RST,
		bod_rst_en: 1'b0
	};

	localparam cprc_dev_st_t ST_RST = '{
		cfg: CFG_RST,
		flags: 6'h08,
		// Pins idle high; a low start would fake a reset
		ext_sync: 2'h3,
		wake_sync: 2'h3,
		pwr: CPRC_PWR_ACTIVE,
		hold: HOLD_CYC,
		fetch_addr: `CPRC_BOOT_ADDR,
		irc_en: 1'b1,
		irc_out_en: 1'b1,
		flash_init: 1'b1,
		default: '0
	};

	cprc_dev_st_t q;
	cprc_dev_st_t d;

	// Clocks stop in every mode deeper than light sleep
	function automatic logic clk_run(cprc_pwr_t p);
		return p == CPRC_PWR_ACTIVE || p == CPRC_PWR_SLEEP
			|| p == CPRC_PWR_RESTORE;
	endfunction : clk_run

	// Lock timer restarts on power-up or any reprogramming
	function automatic logic [LOCK_W-1:0] lock_next(
		logic [LOCK_W-1:0] c, logic on, logic restart);
		if (!on || restart)
			return '0;
		if (c != LOCK_CYC)
			return c + LOCK_W'(1);
		return c;
	endfunction : lock_next

	always_comb begin
		logic setup;
		logic wr;
		logic sys_wr;
		logic usb_wr;
		logic ext_rst;
		logic dpd_wake;
		logic chip_rst;
		logic refused;
		logic [5:0] clr;
		logic [1:0] mode;
		logic running;
		logic deep_evt;
		setup = link.psel & ~link.penable;
		wr = link.psel & link.penable & link.pwrite & q.pready;
		sys_wr = 1'b0;
		usb_wr = 1'b0;
		refused = 1'b0;
		dpd_wake = 1'b0;
		clr = '0;
		mode = q.cfg.pmode[1:0];
		ext_rst = 1'b0;
		chip_rst = 1'b0;
		running = 1'b0;
		deep_evt = 1'b0;
		d = q;
		d.ext_sync = {q.ext_sync[0], ext_resetn};
		d.wake_sync = {q.wake_sync[0], wake_pin_n};
		d.bodl_sync = {q.bodl_sync[0], bod_low};
		d.bodt_sync = {q.bodt_sync[0], bod_trip};
		if (q.ext_sync[1])
			d.ext_low = '0;
		else if (q.ext_low != RMIN_CYC - RMIN_W'(1))
			d.ext_low = q.ext_low + RMIN_W'(1);
		ext_rst = !q.ext_sync[1] && q.ext_low == RMIN_CYC - RMIN_W'(1);
		// Registered answer: one wait-free access phase
		d.pready = setup;
		d.pslverr = setup && (link.paddr[1:0] != 2'b00
			|| link.paddr > `CPRC_OFF_STATUS);
		d.prdata = '0;
		if (setup) begin
			case (link.paddr)
				`CPRC_OFF_MAINSEL: d.prdata[1:0] = q.cfg.main_sel;
				`CPRC_OFF_SYSPLL: d.prdata[7:0] = q.cfg.sys_pll;
				`CPRC_OFF_USBPLL: d.prdata[7:0] = q.cfg.usb_pll;
				`CPRC_OFF_CLOCK_OUT_PIN: d.prdata[1:0] = q.cfg.clock_out_pin_sel;
				`CPRC_OFF_GATE: d.prdata[NPER-1:0] = q.cfg.gate;
				`CPRC_OFF_PMODE: d.prdata[4:0] = q.cfg.pmode;
				`CPRC_OFF_BODCTL: d.prdata[0] = q.cfg.bod_rst_en;
				`CPRC_OFF_STATUS: d.prdata[8:0] = {q.flags, q.bodl_sync[1], q.pll_lock};
				default: d.prdata = '0;
			endcase
		end
		if (wr) begin
			case (link.paddr)
				`CPRC_OFF_MAINSEL: d.cfg.main_sel = link.pwdata[1:0];
				`CPRC_OFF_SYSPLL: begin
					d.cfg.sys_pll = link.pwdata[7:0];
					sys_wr = 1'b1;
				end
				`CPRC_OFF_USBPLL: begin
					d.cfg.usb_pll = link.pwdata[7:0];
					usb_wr = 1'b1;
				end
				`CPRC_OFF_CLOCK_OUT_PIN: d.cfg.clock_out_pin_sel = link.pwdata[1:0];
				`CPRC_OFF_GATE: d.cfg.gate = link.pwdata[NPER-1:0];
				`CPRC_OFF_PMODE: d.cfg.pmode = link.pwdata[4:0];
				`CPRC_OFF_BODCTL: d.cfg.bod_rst_en = link.pwdata[0];
				`CPRC_OFF_STATUS: clr = link.pwdata[8:`CPRC_ST_FLAG_LSB];
				default: ;
			endcase
		end
		// Both PLLs share one lock timer design
		d.sys_cnt = lock_next(q.sys_cnt,
			q.cfg.sys_pll[`CPRC_PLL_PWR_BIT] && clk_run(q.pwr), sys_wr);
		d.usb_cnt = lock_next(q.usb_cnt,
			q.cfg.usb_pll[`CPRC_PLL_PWR_BIT] && clk_run(q.pwr), usb_wr);
		deep_evt = gpio_wake | wdt_irq | usb_irq;
		unique case (q.pwr)
			CPRC_PWR_ACTIVE: begin
				if (link.sleep_req && q.core_rst_n) begin
					unique case (mode)
						`CPRC_MODE_SLEEP: d.pwr = CPRC_PWR_SLEEP;
						`CPRC_MODE_DEEP: d.pwr = CPRC_PWR_DEEP;
						`CPRC_MODE_PD: d.pwr = CPRC_PWR_PD;
						`CPRC_MODE_DPD: begin
							// Falls back to light sleep so the core still stops
							if (q.cfg.pmode[`CPRC_PM_LOCK_BIT]) begin
								d.pwr = CPRC_PWR_SLEEP;
								refused = 1'b1;
							end else begin
								d.pwr = CPRC_PWR_DPD;
							end
						end
					endcase
				end
			end
			CPRC_PWR_SLEEP: begin
				if (link.irq_any)
					d.pwr = CPRC_PWR_ACTIVE;
			end
			CPRC_PWR_DEEP, CPRC_PWR_PD: begin
				if (deep_evt)
					d.pwr = CPRC_PWR_RESTORE;
			end
			CPRC_PWR_RESTORE: begin
				// Powered PLLs must relock before the core may run
				if ((!q.cfg.sys_pll[`CPRC_PLL_PWR_BIT] || q.pll_lock[0])
					&& (!q.cfg.usb_pll[`CPRC_PLL_PWR_BIT] || q.pll_lock[1]))
					d.pwr = CPRC_PWR_ACTIVE;
			end
			CPRC_PWR_DPD: begin
				dpd_wake = !q.wake_sync[1];
			end
		endcase
		chip_rst = ext_rst || wdt_reset || dpd_wake
			|| (q.cfg.bod_rst_en && q.bodt_sync[1]);
		// Set wins over a same-cycle clear
		d.flags = (q.flags & ~clr) | {dpd_wake,
			q.cfg.bod_rst_en & q.bodt_sync[1], 1'b0, wdt_reset, ext_rst,
			refused};
		if (q.hold != '0)
			d.hold = q.hold - HOLD_W'(1);
		d.core_rst_n = q.hold == '0;
		d.flash_init = 1'b0;
		if (chip_rst) begin
			d.cfg = CFG_RST;
			d.pwr = CPRC_PWR_ACTIVE;
			d.sys_cnt = '0;
			d.usb_cnt = '0;
			d.hold = HOLD_CYC;
			d.core_rst_n = 1'b0;
			d.flash_init = 1'b1;
		end
		running = clk_run(d.pwr);
		d.pll_lock = {d.usb_cnt == LOCK_CYC, d.sys_cnt == LOCK_CYC};
		d.core_clk_en = d.pwr == CPRC_PWR_ACTIVE && d.core_rst_n;
		d.per_en = (d.pwr == CPRC_PWR_ACTIVE || d.pwr == CPRC_PWR_SLEEP)
			? d.cfg.gate : '0;
		d.irc_en = chip_rst || (d.pwr != CPRC_PWR_PD
			&& d.pwr != CPRC_PWR_DPD);
		d.irc_out_en = chip_rst || running || (d.pwr == CPRC_PWR_DEEP
			&& d.cfg.pmode[`CPRC_PM_WDIRC_BIT]);
		d.sysosc_en = running && (d.cfg.main_sel == `CPRC_MAIN_SYSOSC
			|| d.cfg.clock_out_pin_sel == `CPRC_CKO_SYSOSC
			|| d.cfg.sys_pll[`CPRC_PLL_PWR_BIT]
			|| d.cfg.usb_pll[`CPRC_PLL_PWR_BIT]);
		d.lowrate_en = (running && (d.cfg.main_sel == `CPRC_MAIN_LOWRATE
			|| d.cfg.clock_out_pin_sel == `CPRC_CKO_LOWRATE))
			|| (d.pwr != CPRC_PWR_DPD
			&& d.cfg.pmode[`CPRC_PM_KEEP_BIT]);
		d.fetch_addr = `CPRC_BOOT_ADDR;
		d.bod_irq = q.bodl_sync[1];
		d.sys_on = d.cfg.sys_pll[`CPRC_PLL_PWR_BIT] && running;
		d.usb_on = d.cfg.usb_pll[`CPRC_PLL_PWR_BIT] && running;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign link.prdata = q.prdata;
	assign link.pready = q.pready;
	assign link.pslverr = q.pslverr;
	assign link.core_clk_en = q.core_clk_en;
	assign link.core_rst_n = q.core_rst_n;
	assign link.pll_lock = q.pll_lock;
	assign link.fetch_addr = q.fetch_addr;
	assign main_sel = q.cfg.main_sel;
	assign clock_out_pin_sel = q.cfg.clock_out_pin_sel;
	assign irc_en = q.irc_en;
	assign irc_out_en = q.irc_out_en;
	assign sysosc_en = q.sysosc_en;
	assign lowrate_en = q.lowrate_en;
	assign sys_pll_msel = q.cfg.sys_pll[4:0];
	assign sys_pll_psel = q.cfg.sys_pll[6:5];
	assign sys_pll_on = q.sys_on;
	assign usb_pll_msel = q.cfg.usb_pll[4:0];
	assign usb_pll_psel = q.cfg.usb_pll[6:5];
	assign usb_pll_on = q.usb_on;
	assign per_clk_en = q.per_en;
	assign flash_init = q.flash_init;
	assign bod_irq = q.bod_irq;
endmodule : cprc_dev
`default_nettype wire

// file: include/cprc_cfg.svh
// Constants of the clock, power and reset controller.
// Included by both ends (cprc_dev, cprc_core); definitions only.
`ifndef CPRC_CFG_SVH
`define CPRC_CFG_SVH
`define CPRC_CLK_MHZ 40
`define CPRC_CLK_NS 25
`define CPRC_IRC_MHZ 12
`define CPRC_USB_MHZ 48
`define CPRC_REF_MIN_KHZ 10000
`define CPRC_REF_MAX_KHZ 25000
`define CPRC_CCO_MIN_KHZ 156000
`define CPRC_CCO_MAX_KHZ 320000
`define CPRC_FOUT_MAX_KHZ 100000
`define CPRC_MULT_MIN 1
`define CPRC_MULT_MAX 32
`define CPRC_PLL_LOCK_US 100
`define CPRC_PLL_LOCK_CYC (`CPRC_PLL_LOCK_US * `CPRC_CLK_MHZ)
`define CPRC_RST_MIN_NS 50
`define CPRC_RST_MIN_CYC \
	((`CPRC_RST_MIN_NS + `CPRC_CLK_NS - 1) / `CPRC_CLK_NS)
`define CPRC_CORE_HOLD_CYC 16
`define CPRC_BOOT_ADDR 32'h0000_0000
`define CPRC_OFF_MAINSEL 8'h00
`define CPRC_OFF_SYSPLL 8'h04
`define CPRC_OFF_USBPLL 8'h08
`define CPRC_OFF_CLOCK_OUT_PIN 8'h0c
`define CPRC_OFF_GATE 8'h10
`define CPRC_OFF_PMODE 8'h14
`define CPRC_OFF_BODCTL 8'h18
`define CPRC_OFF_STATUS 8'h1c
`define CPRC_MAIN_IRC 2'h0
`define CPRC_MAIN_SYSOSC 2'h1
`define CPRC_MAIN_PLL 2'h2
`define CPRC_MAIN_LOWRATE 2'h3
`define CPRC_CKO_IRC 2'h0
`define CPRC_CKO_SYSOSC 2'h1
`define CPRC_CKO_LOWRATE 2'h2
`define CPRC_CKO_MAIN 2'h3
`define CPRC_MODE_SLEEP 2'h0
`define CPRC_MODE_DEEP 2'h1
`define CPRC_MODE_PD 2'h2
`define CPRC_MODE_DPD 2'h3
`define CPRC_PLL_PSEL_LSB 5
`define CPRC_PLL_PWR_BIT 7
`define CPRC_PM_LOCK_BIT 2
`define CPRC_PM_KEEP_BIT 3
`define CPRC_PM_WDIRC_BIT 4
`define CPRC_ST_FLAG_LSB 3
`define CPRC_MAINSEL_RST 2'h0
`define CPRC_PLL_RST 8'h00
`define CPRC_CLOCK_OUT_PIN_RST 2'h0
`define CPRC_PMODE_RST 5'h00
`endif

// file: include/cprc_pkg.sv
// Types shared by both ends of the clock, power and reset controller.
// Assumes cprc_cfg.svh on the include path.
`default_nettype none
package cprc_pkg;
	typedef enum logic [2:0] {
		CPRC_PWR_ACTIVE,
		CPRC_PWR_SLEEP,
		CPRC_PWR_DEEP,
		CPRC_PWR_PD,
		CPRC_PWR_DPD,
		CPRC_PWR_RESTORE
	} cprc_pwr_t;
	typedef enum logic [1:0] {
		CPRC_BUS_IDLE,
		CPRC_BUS_SETUP,
		CPRC_BUS_ACCESS
	} cprc_bus_t;
endpackage : cprc_pkg
`default_nettype wire

// file: include/cprc_link_if.sv
// Link between the controller and the core: APB plus sleep sideband.
// Both ends run on pclk; the bench joins them through this.
`default_nettype none
interface cprc_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleep_req;
	logic irq_any;
	logic core_clk_en;
	logic core_rst_n;
	logic [1:0] pll_lock;
	logic [31:0] fetch_addr;
	modport dev (
		input psel, penable, pwrite, paddr, pwdata, sleep_req, irq_any,
		output prdata, pready, pslverr, core_clk_en, core_rst_n,
		output pll_lock, fetch_addr
	);
	modport core (
		output psel, penable, pwrite, paddr, pwdata, sleep_req, irq_any,
		input prdata, pready, pslverr, core_clk_en, core_rst_n,
		input pll_lock, fetch_addr
	);
endinterface : cprc_link_if
`default_nettype wire

// file: rtl/cprc_core.sv
// Core-side end: APB master for the controller plus sleep handshake.
// Assumes the controller answers on the same pclk through the link.
`include "cprc_cfg.svh"
`default_nettype none
module cprc_core
	import cprc_pkg::*;
#(
	parameter int SYS_REF_KHZ = 12000,
	parameter int USB_REF_KHZ = 12000
) (
	input wire logic pclk,
	input wire logic presetn,
	cprc_link_if.core link,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [31:0] rsp_rdata,
	input wire logic sleep_go,
	input wire logic irq_in
);
	if (SYS_REF_KHZ < 1 || USB_REF_KHZ < 1) begin : g_chk
		$error("PLL reference frequency must be positive");
	end

	typedef struct packed {
		cprc_bus_t st;
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic cmd_ready;
		logic rsp_valid;
		logic rsp_err;
		logic [31:0] rsp_rdata;
		logic sleep_req;
		logic irq_any;
	} cprc_core_st_t;

	cprc_core_st_t q;
	cprc_core_st_t d;

	// Refuses PLL settings the oscillator cannot hold.
	function automatic logic pll_ok(int ref_khz, logic [7:0] w);
		int mult;
		int fout;
		int fcco;
		mult = int'(w[4:0]) + 1;
		fout = ref_khz * mult;
		fcco = fout * (2 << w[6:`CPRC_PLL_PSEL_LSB]);
		return ref_khz >= `CPRC_REF_MIN_KHZ && ref_khz <= `CPRC_REF_MAX_KHZ
			&& fcco >= `CPRC_CCO_MIN_KHZ && fcco <= `CPRC_CCO_MAX_KHZ
			&& fout < `CPRC_FOUT_MAX_KHZ;
	endfunction : pll_ok

	function automatic logic cmd_ok(logic wr, logic [7:0] a,
		logic [31:0] w, logic [1:0] lock);
		logic ok;
		ok = 1'b1;
		if (wr && a == `CPRC_OFF_SYSPLL && w[`CPRC_PLL_PWR_BIT])
			ok = pll_ok(SYS_REF_KHZ, w[7:0]);
		if (wr && a == `CPRC_OFF_USBPLL && w[`CPRC_PLL_PWR_BIT])
			ok = pll_ok(USB_REF_KHZ, w[7:0]);
		if (wr && a == `CPRC_OFF_MAINSEL && w[1:0] == `CPRC_MAIN_PLL)
			ok = lock[0];
		return ok;
	endfunction : cmd_ok

	always_comb begin
		logic running;
		running = link.core_clk_en & link.core_rst_n;
		d = q;
		d.rsp_valid = 1'b0;
		d.irq_any = irq_in;
		unique case (q.st)
			CPRC_BUS_IDLE: begin
				if (cmd_valid && q.cmd_ready) begin
					if (cmd_ok(cmd_write, cmd_addr, cmd_wdata, link.pll_lock)) begin
						d.st = CPRC_BUS_SETUP;
						d.psel = 1'b1;
						d.pwrite = cmd_write;
						d.paddr = cmd_addr;
						d.pwdata = cmd_wdata;
					end else begin
						d.rsp_valid = 1'b1;
						d.rsp_err = 1'b1;
						d.rsp_rdata = 32'h0000_0000;
					end
				end
			end
			CPRC_BUS_SETUP: begin
				d.st = CPRC_BUS_ACCESS;
				d.penable = 1'b1;
			end
			CPRC_BUS_ACCESS: begin
				if (link.pready) begin
					d.st = CPRC_BUS_IDLE;
					d.psel = 1'b0;
					d.penable = 1'b0;
					d.rsp_valid = 1'b1;
					d.rsp_err = link.pslverr;
					d.rsp_rdata = link.prdata;
				end
			end
		endcase
		// Held until the clock stops, so the request is never missed
		if (sleep_go && !q.sleep_req && q.st == CPRC_BUS_IDLE && running)
			d.sleep_req = 1'b1;
		else if (q.sleep_req && !link.core_clk_en)
			d.sleep_req = 1'b0;
		d.cmd_ready = d.st == CPRC_BUS_IDLE && running && !d.sleep_req
			&& !(cmd_valid && q.cmd_ready);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{st: CPRC_BUS_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign link.psel = q.psel;
	assign link.penable = q.penable;
	assign link.pwrite = q.pwrite;
	assign link.paddr = q.paddr;
	assign link.pwdata = q.pwdata;
	assign link.sleep_req = q.sleep_req;
	assign link.irq_any = q.irq_any;
	assign cmd_ready = q.cmd_ready;
	assign rsp_valid = q.rsp_valid;
	assign rsp_err = q.rsp_err;
	assign rsp_rdata = q.rsp_rdata;
endmodule : cprc_core
`default_nettype wire

// file: dv/cprc_checker.sv
// Checker watching the link between controller and core end.
// Assumes one pclk domain and presetn active low.
`default_nettype none
module cprc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic sleep_req,
	input wire logic core_clk_en,
	input wire logic core_rst_n,
	input wire logic [1:0] pll_lock,
	input wire logic [31:0] fetch_addr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_access_follows: assert property (s_setup |=> s_access)
		else $error("no access phase after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property ($rose(pready) |->
		$past(psel) && !$past(penable))
		else $error("pready without setup");
	a_refused_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_fetch_zero: assert property (core_rst_n |-> fetch_addr == 32'h0)
		else $error("boot fetch not at zero");
	// Sixteen-cycle hold; eight is the cheapest count that still bites
	a_core_hold: assert property ($rose(presetn) |-> !core_rst_n [*8])
		else $error("core released too early");
	a_clk_in_reset: assert property (!core_rst_n |-> !core_clk_en)
		else $error("core clock runs in reset");
	a_release_state: assert property ($rose(core_rst_n) |->
		core_clk_en && pll_lock == 2'h0)
		else $error("core start state wrong");
	a_sleep_stop: assert property ($rose(sleep_req) |-> ##[1:3] !core_clk_en)
		else $error("core clock not stopped");
	a_req_drop: assert property (sleep_req && !core_clk_en |-> ##[0:2] !sleep_req)
		else $error("sleep request stuck");
endmodule : cprc_checker
`default_nettype wire

// file: dv/tb.sv
// Bench joining the controller and the core end through the link.
// Assumes rtl and include files compiled first; one 40 MHz clock.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NP = 16;
	logic pclk, presetn, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_err;
	logic [7:0] cmd_addr;
	logic [31:0] cmd_wdata, rsp_rdata, rdat;
	logic sleep_go, irq_in, ext_resetn, wdt_reset, bod_low, bod_trip, rerr;
	logic wake_pin_n, gpio_wake, wdt_irq, usb_irq, lowrate_en;
	logic [1:0] main_sel, clock_out_pin_sel, sys_pll_psel, usb_pll_psel;
	logic irc_en, irc_out_en, sys_pll_on, usb_pll_on, flash_init, bod_irq;
	logic sysosc_en;
	logic [4:0] sys_pll_msel, usb_pll_msel;
	logic [NP-1:0] per_clk_en;
	int n_fail = 0;
	int n_checks = 0;
	int n_fi = 0;
	int n0;
	cprc_link_if link (.pclk, .presetn);
	cprc_dev #(.NPER(NP)) u_cprc_dev (.pclk, .presetn, .link, .ext_resetn,
		.wdt_reset, .bod_low, .bod_trip, .wake_pin_n, .gpio_wake, .wdt_irq,
		.usb_irq, .main_sel, .clock_out_pin_sel, .irc_en, .irc_out_en, .sysosc_en,
		.lowrate_en, .sys_pll_msel, .sys_pll_psel, .sys_pll_on,
		.usb_pll_msel, .usb_pll_psel, .usb_pll_on, .per_clk_en,
		.flash_init, .bod_irq);
	cprc_core u_cprc_core (.pclk, .presetn, .link, .cmd_valid, .cmd_write,
		.cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_err, .rsp_rdata,
		.sleep_go, .irq_in);
	cprc_checker u_cprc_checker (.pclk, .presetn, .psel(link.psel),
		.penable(link.penable), .pready(link.pready), .pslverr(link.pslverr),
		.prdata(link.prdata), .sleep_req(link.sleep_req),
		.core_clk_en(link.core_clk_en), .core_rst_n(link.core_rst_n),
		.pll_lock(link.pll_lock), .fetch_addr(link.fetch_addr));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Pulse is one cycle, so count it rather than try to catch it
	always @(posedge pclk) if (flash_init === 1'b1) n_fi <= n_fi + 1;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		// Held until an edge sees ready; sleep or reset may delay it
		do begin
			@(posedge pclk);
			i++;
		end while (cmd_ready !== 1'b1 && i < 9000);
		cmd_valid <= 1'b0;
		#1;
		i = 0;
		while (rsp_valid !== 1'b1 && i < 20) begin
			tick(1);
			i++;
		end
		if (rsp_valid !== 1'b1)
			n_fail++;
		rerr = rsp_err;
		rdat = rsp_rdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		xfer(1'b1, a, d);
		chk($sformatf("err %h", a), 32'(rerr), 32'(e));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rdat & m, e);
	endtask : rd
	task automatic wait_en(input logic v);
		int i;
		i = 0;
		while (link.core_clk_en !== v && i < 6000) begin
			tick(1);
			i++;
		end
		chk("clk_en", 32'(link.core_clk_en), 32'(v));
	endtask : wait_en
	task automatic nap(input logic [31:0] m);
		wr(8'h14, m, 1'b0);
		@(posedge pclk);
		sleep_go <= 1'b1;
		@(posedge pclk);
		sleep_go <= 1'b0;
		wait_en(1'b0);
	endtask : nap
	initial begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		end_sim();
	end
	initial begin
		{presetn, cmd_valid, cmd_write, sleep_go, irq_in} = 5'h0;
		{wdt_reset, bod_low, bod_trip, gpio_wake, wdt_irq, usb_irq} = 6'h0;
		{ext_resetn, wake_pin_n} = 2'b11;
		cmd_addr = 8'h0;
		cmd_wdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h3, 32'h0);
		rd(8'h04, 32'hff, 32'h0);
		rd(8'h08, 32'hff, 32'h0);
		rd(8'h0c, 32'h3, 32'h0);
		rd(8'h10, 32'hffff, 32'hffff);
		rd(8'h14, 32'h1f, 32'h0);
		rd(8'h1c, 32'h1ff, 32'h40);
		chk("irc", 32'(irc_en), 32'h1);
		wr(8'h20, 32'h1, 1'b1);
		wr(8'h02, 32'h1, 1'b1);
		for (int k = 0; k < 4; k++) begin
			wr(8'h0c, 32'(k), 1'b0);
			chk("cko", 32'(clock_out_pin_sel), 32'(k));
			wr(8'h04, (32'(k) << 5) | 32'h1f, 1'b0);
			chk("psel", 32'(sys_pll_psel), 32'(k));
			chk("msel", 32'(sys_pll_msel), 32'h1f);
		end
		wr(8'h10, 32'ha5a5, 1'b0);
		chk("gate", 32'(per_clk_en), 32'ha5a5);
		wr(8'h10, 32'hffff, 1'b0);
		wr(8'h04, 32'h88, 1'b1);
		chk("pll_off", 32'(sys_pll_on), 32'h0);
		wr(8'h00, 32'h2, 1'b1);
		wr(8'h04, 32'h87, 1'b0);
		wr(8'h08, 32'ha3, 1'b0);
		chk("pll_on", 32'({sys_pll_on, usb_pll_on}), 32'h3);
		chk("usb_pll", 32'({usb_pll_psel, usb_pll_msel}), 32'h23);
		chk("osc", 32'(sysosc_en), 32'h1);
		tick(4100);
		chk("lock", 32'(link.pll_lock), 32'h3);
		wr(8'h00, 32'h2, 1'b0);
		nap(32'h0);
		chk("per", 32'(per_clk_en), 32'hffff);
		@(posedge pclk);
		irq_in <= 1'b1;
		wait_en(1'b1);
		@(posedge pclk);
		irq_in <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			nap(k == 2 ? 32'h11 : 32'h1);
			chk("per", 32'(per_clk_en), 32'h0);
			chk("rc", 32'({irc_en, irc_out_en, sys_pll_on, sysosc_en}),
				32'(k == 2 ? 4'hc : 4'h8));
			@(posedge pclk);
			gpio_wake <= (k == 0);
			wdt_irq <= (k == 1);
			usb_irq <= (k == 2);
			repeat (2) @(posedge pclk);
			{gpio_wake, wdt_irq, usb_irq} <= 3'h0;
			wait_en(1'b1);
			chk("sel", 32'(main_sel), 32'h2);
			chk("lock", 32'(link.pll_lock), 32'h3);
		end
		nap(32'ha);
		chk("pd", 32'({irc_en, lowrate_en, per_clk_en}), 32'h10000);
		@(posedge pclk);
		irq_in <= 1'b1;
		repeat (10) @(posedge pclk);
		irq_in <= 1'b0;
		#1;
		chk("pd_irq", 32'(link.core_clk_en), 32'h0);
		@(posedge pclk);
		gpio_wake <= 1'b1;
		repeat (2) @(posedge pclk);
		gpio_wake <= 1'b0;
		wait_en(1'b1);
		nap(32'h7);
		@(posedge pclk);
		irq_in <= 1'b1;
		wait_en(1'b1);
		@(posedge pclk);
		irq_in <= 1'b0;
		rd(8'h1c, 32'h8, 32'h8);
		wr(8'h1c, 32'h1f8, 1'b0);
		nap(32'h3);
		@(posedge pclk);
		gpio_wake <= 1'b1;
		repeat (10) @(posedge pclk);
		gpio_wake <= 1'b0;
		#1;
		chk("dpd", 32'(link.core_clk_en), 32'h0);
		@(posedge pclk);
		wake_pin_n <= 1'b0;
		repeat (3) @(posedge pclk);
		wake_pin_n <= 1'b1;
		rd(8'h1c, 32'h100, 32'h100);
		rd(8'h00, 32'h3, 32'h0);
		chk("pll_off", 32'({sys_pll_on, usb_pll_on}), 32'h0);
		wr(8'h00, 32'h1, 1'b0);
		n0 = n_fi;
		@(posedge pclk);
		ext_resetn <= 1'b0;
		repeat (2) @(posedge pclk);
		ext_resetn <= 1'b1;
		rd(8'h1c, 32'h10, 32'h10);
		rd(8'h00, 32'h3, 32'h0);
		chk("flash", 32'(n_fi > n0), 32'h1);
		@(posedge pclk);
		wdt_reset <= 1'b1;
		@(posedge pclk);
		wdt_reset <= 1'b0;
		rd(8'h1c, 32'h20, 32'h20);
		@(posedge pclk);
		bod_low <= 1'b1;
		tick(4);
		chk("bod_irq", 32'(bod_irq), 32'h1);
		rd(8'h1c, 32'h4, 32'h4);
		@(posedge pclk);
		bod_low <= 1'b0;
		wr(8'h18, 32'h1, 1'b0);
		@(posedge pclk);
		bod_trip <= 1'b1;
		repeat (4) @(posedge pclk);
		bod_trip <= 1'b0;
		rd(8'h1c, 32'h80, 32'h80);
		end_sim();
	end
endmodule : tb
`default_nettype wire
